// File: design/mmi_i2c_ctrl.v
// Purpose: multimaster two-wire bus controller with AXI4-Lite registers
// Assumes: bus lines open drain with external pull-ups, 50 MHz aclk
// Notes:   serial lines are sampled, not used as clocks
//
// Behaviour
// - idle stop, bus mode and wakeup mode
// - 8-bit transfers over two lines
// - master issues conditions; slave detects in hardware
// - lines only pulled low or released
// - wakeup: address or extension raises interrupt
// - one shift register for both directions
// - shift write during stretch resumes transfer
// - shift and own address reset to zero
// - own address in upper bits, bit0 zero
// - latch holds driven data level
// - interrupt on address match or extension
// - clock counter marks byte completion
// - interrupt at clock 8/9 or stop
// - master makes clock from sampling counter
// - data held after clock falling edge
// - start trigger; busy without reservation fails
// - stop trigger makes stop condition
// - bus state tracked, initial from permit bit
// - clock enable low holds block reset
// - operation enable clear stops and clears status
// - exit releases lines, clears flags
// - cancel at ninth clock releases data
`timescale 1ns/1ps
`include "mmi_defines.vh"

module mmi_i2c_ctrl (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output wire [1:0]  s_axi_bresp,
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        bus_clock_pin_in,
    output wire        bus_clock_pin_out,
    output wire        bus_clock_pin_oe,
    input  wire        bus_data_pin_in,
    output wire        bus_data_pin_out,
    output wire        bus_data_pin_oe,
    output wire        bus_irq
);

    localparam S_IDLE = 4'd0;
    localparam S_SA   = 4'd1;
    localparam S_SB   = 4'd2;
    localparam S_SC   = 4'd3;
    localparam S_LOW  = 4'd4;
    localparam S_HIGH = 4'd5;
    localparam S_PA   = 4'd6;
    localparam S_PB   = 4'd7;
    localparam S_PC   = 4'd8;

    function hit;
        input [7:0] a;
        input [7:0] off;
        hit = (a[7:2] == off[7:2]);
    endfunction

    // ---------------------------------------------------------------
    // AXI4-Lite handshake
    // ---------------------------------------------------------------
    reg        awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    reg        aw_got_r, w_got_r;
    reg [7:0]  waddr_r;
    reg [31:0] wd;
    reg [3:0]  wstrb_r;
    reg [1:0]  bresp_r, rresp_r;
    reg [31:0] rdata_r;
    reg        per_en_r;
    wire       do_wr = aw_got_r & w_got_r & ~bvalid_r;
    wire       wmap  = waddr_r <= `MMI_OFF_WID;
    wire       wr_ok = do_wr & per_en_r & wstrb_r[0];
    wire       wr_shift = wr_ok & hit(waddr_r, `MMI_OFF_SHIFT);
    wire       wr_sva   = wr_ok & hit(waddr_r, `MMI_OFF_SVA);
    wire       wr_ctla  = wr_ok & hit(waddr_r, `MMI_OFF_CTLA);
    wire       wr_flag  = wr_ok & hit(waddr_r, `MMI_OFF_FLAG);
    wire       wr_ctlb  = wr_ok & hit(waddr_r, `MMI_OFF_CTLB);
    wire       wr_wid   = do_wr & per_en_r & hit(waddr_r, `MMI_OFF_WID);

    // ---------------------------------------------------------------
    // controller state
    // ---------------------------------------------------------------
    reg [7:0]  shift_r, sva_r;
    reg        open_r, spie_r, wtim_r, acke_r, stt_r, spt_r;
    reg        rsv_r, start_permit_init_r, start_fail_flag_r, busy_r, wup_r;
    reg [15:0] wid_r;
    reg        msts_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r;
    reg [3:0]  bitcnt_r, mst_r;
    reg        addr_ph_r, stretch_r, pend_r, sda_low_r, m_scl_low_r;
    reg        scl_oe_r, irq_r, zero_r;
    reg [7:0]  hold_r, wcnt_r;
    wire [1:0] sy2_w;
    reg        scl_d_r, sda_d_r;
    wire [7:0] st_word = {msts_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r};
    wire [7:0] ca_word = {open_r, 2'b00, spie_r, wtim_r, acke_r, stt_r, spt_r};
    wire [7:0] fl_word = {start_fail_flag_r, busy_r, 4'h0, start_permit_init_r, rsv_r};

    always @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
            arready_r <= 1'b1;
            bvalid_r  <= 1'b0;
            rvalid_r  <= 1'b0;
            aw_got_r  <= 1'b0;
            w_got_r   <= 1'b0;
            waddr_r   <= 8'h00;
            wd        <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bresp_r   <= `MMI_RESP_OK;
            rresp_r   <= `MMI_RESP_OK;
            rdata_r   <= 32'h0000_0000;
            per_en_r  <= 1'b0;
        end else begin
            if (s_axi_awvalid && awready_r) begin
                aw_got_r  <= 1'b1;
                awready_r <= 1'b0;
                waddr_r   <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_r) begin
                w_got_r  <= 1'b1;
                wready_r <= 1'b0;
                wd       <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (do_wr) begin
                bvalid_r <= 1'b1;
                bresp_r  <= wmap ? `MMI_RESP_OK : `MMI_RESP_ERR;
                if (hit(waddr_r, `MMI_OFF_PER) && wstrb_r[0])
                    per_en_r <= wd[`MMI_PER_EN];
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                aw_got_r  <= 1'b0;
                w_got_r   <= 1'b0;
                awready_r <= 1'b1;
                wready_r  <= 1'b1;
            end
            if (s_axi_arvalid && arready_r) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                rresp_r   <= (s_axi_araddr <= `MMI_OFF_WID) ? `MMI_RESP_OK : `MMI_RESP_ERR;
                case (s_axi_araddr[7:2])
                    6'd0:    rdata_r <= {24'h0, shift_r};
                    6'd1:    rdata_r <= {24'h0, sva_r};
                    6'd2:    rdata_r <= {24'h0, ca_word};  // exit/cancel read 0
                    6'd3:    rdata_r <= {24'h0, fl_word};
                    6'd4:    rdata_r <= {24'h0, st_word};
                    6'd5:    rdata_r <= {31'h0, wup_r};
                    6'd6:    rdata_r <= {27'h0, per_en_r, 4'h0};
                    6'd7:    rdata_r <= {16'h0, wid_r};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r  <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // line synchronisers
    // ---------------------------------------------------------------
    wire [1:0] pin_in = {bus_data_pin_in, bus_clock_pin_in};
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            reg s1_r, s2_r;
            always @(posedge aclk) begin
                if (!aresetn) begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                end else begin
                    s1_r <= pin_in[gi];
                    s2_r <= s1_r;
                end
            end
            assign sy2_w[gi] = s2_r;
        end
    endgenerate

    wire scl_s    = sy2_w[0];
    wire sda_s    = sy2_w[1];
    wire scl_rise = scl_s & ~scl_d_r;
    wire scl_fall = ~scl_s & scl_d_r;
    wire st_det   = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire sp_det   = scl_s & scl_d_r & ~sda_d_r & sda_s;
    wire part     = msts_r | coi_r | exc_r;
    wire [7:0] nb = {shift_r[6:0], sda_s};
    wire match    = (nb[7:1] == sva_r[7:1]);
    wire extc     = (nb[7:4] == `MMI_EXT_CODE);
    wire lo_done  = wcnt_r >= wid_r[7:0];
    wire hi_done  = wcnt_r >= wid_r[15:8];
    wire rst_i    = ~aresetn | ~per_en_r;
    wire [31:0] hold_calc = `MMI_HOLD_CYC;
    wire [7:0]  hold_cyc  = hold_calc[7:0];

    // ---------------------------------------------------------------
    // protocol engine and control registers
    // ---------------------------------------------------------------
    always @(posedge aclk) begin
        if (rst_i) begin
            shift_r <= `MMI_RST_BYTE;
            sva_r   <= `MMI_RST_BYTE;
            {open_r, spie_r, wtim_r, acke_r, stt_r, spt_r} <= 6'h00;
            {rsv_r, start_permit_init_r, start_fail_flag_r, busy_r, wup_r} <= 5'h00;
            wid_r   <= `MMI_RST_WID;
            {msts_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r} <= 8'h00;
            bitcnt_r <= 4'd0;
            mst_r    <= S_IDLE;
            {addr_ph_r, stretch_r, pend_r, sda_low_r, m_scl_low_r} <= 5'h00;
            {scl_oe_r, irq_r, zero_r} <= 3'h0;
            hold_r  <= 8'h00;
            wcnt_r  <= 8'h00;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r  <= scl_s;
            sda_d_r  <= sda_s;
            irq_r    <= 1'b0;
            scl_oe_r <= open_r & (stretch_r | m_scl_low_r);
            if (wr_sva) sva_r <= {wd[7:1], 1'b0};
            if (wr_ctlb) wup_r <= wd[`MMI_CB_WUP];
            if (wr_flag) begin
                rsv_r   <= wd[`MMI_FL_RSV];
                start_permit_init_r <= wd[`MMI_FL_START_PERMIT_INIT];
            end
            if (wr_wid && wstrb_r[0]) wid_r[7:0] <= wd[7:0];
            if (wr_wid && wstrb_r[1]) wid_r[15:8] <= wd[15:8];
            if (wr_ctla) begin
                open_r <= wd[`MMI_CA_OPEN];
                spie_r <= wd[`MMI_CA_SPIE];
                wtim_r <= wd[`MMI_CA_WTIM];
                acke_r <= wd[`MMI_CA_ACKE];
            end
            if (wr_shift) shift_r <= wd[7:0];
            if (!open_r) begin
                // idle stop: no transfers, status and bus state cleared
                {msts_r, ald_r, exc_r, coi_r, trc_r, ackd_r, std_r, spd_r} <= 8'h00;
                {start_fail_flag_r, busy_r, stt_r, spt_r} <= 4'h0;
                {addr_ph_r, stretch_r, sda_low_r, m_scl_low_r} <= 4'h0;
                mst_r    <= S_IDLE;
                bitcnt_r <= 4'd0;
                hold_r   <= 8'h00;
                if (wr_ctla && wd[`MMI_CA_OPEN])
                    busy_r <= ~start_permit_init_r;
            end else begin
                // bus state and condition detection
                if (st_det) begin
                    {std_r, spd_r, busy_r, addr_ph_r} <= 4'b1011;
                    {coi_r, exc_r} <= 2'b00;
                    bitcnt_r <= 4'd0;
                    if (!msts_r) trc_r <= 1'b0;
                end else if (sp_det) begin
                    {spd_r, std_r, busy_r, addr_ph_r} <= 4'b1000;
                    {msts_r, coi_r, exc_r, trc_r} <= 4'h0;
                    bitcnt_r <= 4'd0;
                    if (spie_r && !wup_r) irq_r <= 1'b1;
                end else if (scl_rise && bitcnt_r < 4'd9 && (addr_ph_r || part)) begin
                    bitcnt_r <= bitcnt_r + 4'd1;
                    if (bitcnt_r < 4'd8) shift_r <= nb;
                    if (bitcnt_r == 4'd8 && trc_r) ackd_r <= ~sda_s;
                    if (msts_r && trc_r && bitcnt_r < 4'd8 && !sda_low_r && !sda_s) begin
                        // lost arbitration: drop out, keep listening
                        {ald_r, msts_r, trc_r, m_scl_low_r} <= 4'b1000;
                        mst_r <= S_IDLE;
                    end else if (addr_ph_r && bitcnt_r == 4'd7) begin
                        if (msts_r) begin
                            trc_r <= ~nb[0];
                        end else begin
                            coi_r <= match;
                            exc_r <= extc;
                            trc_r <= nb[0] & match;
                            if (!match && !extc) addr_ph_r <= 1'b0;
                            if (wup_r && (match || extc)) irq_r <= 1'b1;
                        end
                    end
                end else if (scl_fall && part) begin
                    hold_r <= hold_cyc;
                    if (bitcnt_r == 4'd8) begin
                        pend_r <= addr_ph_r ? (~msts_r & (coi_r | (exc_r & acke_r)))
                                            : (acke_r & ~trc_r);
                        if (!wtim_r) begin
                            stretch_r <= 1'b1;
                            irq_r <= ~wup_r;
                        end
                    end else if (bitcnt_r == 4'd9) begin
                        pend_r    <= 1'b0;
                        bitcnt_r  <= 4'd0;
                        addr_ph_r <= 1'b0;
                        if (wtim_r) begin
                            stretch_r <= 1'b1;
                            irq_r <= ~wup_r;
                        end
                    end else begin
                        pend_r <= trc_r & ~shift_r[7];
                    end
                end
                if (hold_r != 8'h00) begin
                    hold_r <= hold_r - 8'h01;
                    if (hold_r == 8'h01) sda_low_r <= pend_r;
                end

                // master clock and condition generator
                case (mst_r)
                    S_IDLE: begin
                        wcnt_r <= 8'h00;
                        if (stt_r && !busy_r) mst_r <= S_SA;  // reserved start runs here
                        if (spt_r && !msts_r) spt_r <= 1'b0;
                    end
                    S_SA: begin
                        sda_low_r <= 1'b0;
                        wcnt_r <= lo_done ? 8'h00 : wcnt_r + 8'h01;
                        if (lo_done) begin
                            {m_scl_low_r, stretch_r} <= 2'b00;
                            mst_r <= S_SB;
                        end
                    end
                    S_SB: begin
                        wcnt_r <= (!scl_s || hi_done) ? 8'h00 : wcnt_r + 8'h01;
                        if (scl_s && hi_done) mst_r <= S_SC;
                    end
                    S_SC: begin
                        sda_low_r <= 1'b1;
                        wcnt_r <= hi_done ? 8'h00 : wcnt_r + 8'h01;
                        if (hi_done) begin
                            {m_scl_low_r, msts_r, trc_r, stretch_r} <= 4'hf;
                            stt_r <= 1'b0;
                            mst_r <= S_LOW;
                        end
                    end
                    S_LOW: begin
                        m_scl_low_r <= 1'b1;
                        if (spt_r) begin
                            wcnt_r <= 8'h00;
                            mst_r  <= S_PA;
                        end else if (stt_r) begin
                            wcnt_r <= 8'h00;
                            mst_r  <= S_SA;
                        end else begin
                            wcnt_r <= (stretch_r || lo_done) ? 8'h00 : wcnt_r + 8'h01;
                            if (!stretch_r && lo_done) begin
                                m_scl_low_r <= 1'b0;
                                mst_r <= S_HIGH;
                            end
                        end
                    end
                    S_HIGH: begin
                        // waits for the line to rise, so a slave may stretch
                        wcnt_r <= (!scl_s || hi_done) ? 8'h00 : wcnt_r + 8'h01;
                        if (scl_s && hi_done) begin
                            m_scl_low_r <= 1'b1;
                            mst_r <= S_LOW;
                        end
                    end
                    S_PA: begin
                        sda_low_r <= 1'b1;
                        wcnt_r <= lo_done ? 8'h00 : wcnt_r + 8'h01;
                        if (lo_done) begin
                            {m_scl_low_r, stretch_r} <= 2'b00;
                            mst_r <= S_PB;
                        end
                    end
                    S_PB: begin
                        wcnt_r <= (!scl_s || hi_done) ? 8'h00 : wcnt_r + 8'h01;
                        if (scl_s && hi_done) mst_r <= S_PC;
                    end
                    S_PC: begin
                        sda_low_r <= 1'b0;
                        wcnt_r <= hi_done ? 8'h00 : wcnt_r + 8'h01;
                        if (hi_done) begin
                            {spt_r, msts_r} <= 2'b00;
                            mst_r <= S_IDLE;
                        end
                    end
                    default: mst_r <= S_IDLE;
                endcase

                // software actions last, so they win over engine updates
                if (wr_shift) begin
                    stretch_r <= 1'b0;
                    if (bitcnt_r != 4'd8) sda_low_r <= trc_r & ~wd[7];
                end
                if (wr_ctla && wd[`MMI_CA_STT]) begin
                    if (busy_r && !msts_r && rsv_r) begin
                        start_fail_flag_r <= 1'b1;
                    end else begin
                        stt_r  <= 1'b1;
                        start_fail_flag_r <= 1'b0;
                    end
                end
                if (wr_ctla && wd[`MMI_CA_SPT]) spt_r <= 1'b1;
                if (wr_ctla && wd[`MMI_CA_WCAN]) begin
                    stretch_r <= 1'b0;
                    if (bitcnt_r == 4'd0 && trc_r) begin
                        trc_r     <= 1'b0;
                        sda_low_r <= 1'b0;
                    end
                end
                if (wr_ctla && wd[`MMI_CA_EXIT]) begin
                    // lines released, idle until the next start
                    {stt_r, spt_r, msts_r, exc_r, coi_r, trc_r, ackd_r, std_r} <= 8'h00;
                    {sda_low_r, m_scl_low_r, stretch_r, addr_ph_r} <= 4'h0;
                    hold_r <= 8'h00;
                    mst_r  <= S_IDLE;
                end
            end
        end
    end

    assign s_axi_awready     = awready_r;
    assign s_axi_wready      = wready_r;
    assign s_axi_bresp       = bresp_r;
    assign s_axi_bvalid      = bvalid_r;
    assign s_axi_arready     = arready_r;
    assign s_axi_rdata       = rdata_r;
    assign s_axi_rresp       = rresp_r;
    assign s_axi_rvalid      = rvalid_r;
    assign bus_clock_pin_out = zero_r;
    assign bus_clock_pin_oe  = scl_oe_r;
    assign bus_data_pin_out  = zero_r;
    assign bus_data_pin_oe   = sda_low_r;
    assign bus_irq           = irq_r;

endmodule // mmi_i2c_ctrl

// File: design/mmi_defines.vh
// Purpose: constants of the multimaster two-wire bus controller
// Assumes: 50 MHz aclk, AXI4-Lite register access
// Notes:   byte addresses, bit positions, reset values, timing counts
`ifndef MMI_DEFINES_VH
`define MMI_DEFINES_VH

// ---------------------------------------------------------------
// register byte addresses
// ---------------------------------------------------------------
`define MMI_OFF_SHIFT  8'h00
`define MMI_OFF_SVA    8'h04
`define MMI_OFF_CTLA   8'h08
`define MMI_OFF_FLAG   8'h0c
`define MMI_OFF_STAT   8'h10
`define MMI_OFF_CTLB   8'h14
`define MMI_OFF_PER    8'h18
`define MMI_OFF_WID    8'h1c

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define MMI_CA_OPEN    7
`define MMI_CA_EXIT    6
`define MMI_CA_WCAN    5
`define MMI_CA_SPIE    4
`define MMI_CA_WTIM    3
`define MMI_CA_ACKE    2
`define MMI_CA_STT     1
`define MMI_CA_SPT     0
`define MMI_FL_START_FAIL_FLAG    7
`define MMI_FL_BSY     6
`define MMI_FL_START_PERMIT_INIT   1
`define MMI_FL_RSV     0
`define MMI_CB_WUP     0
`define MMI_PER_EN     4

// ---------------------------------------------------------------
// reset values and codes
// ---------------------------------------------------------------
`define MMI_RST_BYTE   8'h00
// scl low width 250 cycles, high width 200 cycles
`define MMI_RST_WID    16'hc8fa
`define MMI_EXT_CODE   4'hf
`define MMI_RESP_OK    2'b00
`define MMI_RESP_ERR   2'b10

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define MMI_CLK_MHZ    50
`define MMI_HOLD_NS    20
`define MMI_HOLD_CYC   ((`MMI_HOLD_NS * `MMI_CLK_MHZ + 999) / 1000)

`endif

// File: bench/mmi_chk_sva.sv
// Purpose: port checker of the bus controller
// Assumes: one aclk domain, sync active-low reset
// Notes:   attached to every controller instance
`timescale 1ns/1ps
module mmi_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire [7:0]  s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        bus_clock_pin_out,
    input wire        bus_data_pin_out,
    input wire        bus_irq
);
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_scl_drain: assert property (bus_clock_pin_out == 1'b0) else $error("scl driven");
    a_sda_drain: assert property (bus_data_pin_out == 1'b0) else $error("sda driven");
    a_irq_pulse: assert property (bus_irq |=> !bus_irq) else $error("irq too long");
    a_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("no write answer");
    a_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken too early");
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read answer");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data moved");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h1c
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0) else $error("bad read answer");
    c_irq: cover property (bus_irq);
    c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
    c_wr: cover property (s_axi_bvalid);
endmodule // mmi_chk
bind mmi_i2c_ctrl mmi_chk chk_u (.*);

// File: bench/mmi_peer.sv
// Purpose: outside bus master driving slave traffic
// Assumes: 160 ns serial clock, pull-ups on both wires
// Notes:   a stretch longer than 4 us is given up on
`timescale 1ns/1ps
module mmi_peer (
    input  wire scl,
    input  wire sda,
    output reg  scl_oe,
    output reg  sda_oe
);
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
    end
    task rise;
        integer n;
        begin
            scl_oe = 1'b0;
            n = 0;
            while (scl !== 1'b1 && n < 200) begin
                #20;
                n = n + 1;
            end
            #80;
        end
    endtask
    task frame(input [7:0] b, output reg ack);
        integer k;
        begin
            sda_oe = 1'b1;
            #80;
            for (k = 7; k >= -1; k = k - 1) begin
                scl_oe = 1'b1;
                #40;
                sda_oe = (k >= 0) ? ~b[k] : 1'b0;
                #40;
                rise;
                if (k < 0) ack = ~sda;
            end
            scl_oe = 1'b1;
        end
    endtask
    task stop;
        begin
            sda_oe = 1'b1;
            #40;
            rise;
            sda_oe = 1'b0;
            #80;
        end
    endtask
endmodule // mmi_peer

// File: bench/testbench.sv
// Purpose: register-level tests of the bus controller
// Assumes: 50 MHz aclk, pull-ups on both serial lines
// Notes:   the peer plays the outside master
`timescale 1ns/1ps
module testbench;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ack;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata;
    wire        awready, wready, bvalid, arready, rvalid, irq, c_oe, d_oe, pc_oe, pd_oe;
    wire [1:0]  rresp;
    wire [31:0] rdata;
    wire        scl = ~(c_oe | pc_oe);
    wire        sda = ~(d_oe | pd_oe);
    integer     miscompares = 0, num_checks = 0, irqs = 0, i;
    mmi_i2c_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .bus_clock_pin_in(scl), .bus_clock_pin_out(), .bus_clock_pin_oe(c_oe),
        .bus_data_pin_in(sda), .bus_data_pin_out(), .bus_data_pin_oe(d_oe), .bus_irq(irq));
    mmi_peer peer_u (.scl(scl), .sda(sda), .scl_oe(pc_oe), .sda_oe(pd_oe));
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    always @(posedge aclk) if (irq === 1'b1) irqs <= irqs + 1;
    task chk(input string n, input [31:0] e, input [31:0] g);
        begin
            num_checks = num_checks + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("unexpected %s: expected %h, seen %h", n, e, g);
            end
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        begin
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            @(posedge aclk);
            while (awvalid | wvalid | bready) begin
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
                if (bvalid) bready <= 1'b0;
                @(posedge aclk);
            end
        end
    endtask
    task rdchk(input [7:0] a, input [31:0] e, input [31:0] m);
        begin
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            @(posedge aclk);
            while (arvalid | rready) begin
                if (arready) arvalid <= 1'b0;
                if (rvalid) begin
                    rready <= 1'b0;
                    chk("rdata", e, rdata & m);
                    chk("rresp", (a > 8'h1c) ? 32'h2 : 32'h0, {30'h0, rresp});
                end
                @(posedge aclk);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d, mismatches %0d", num_checks, miscompares);
            if (miscompares == 0 && num_checks > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #1000000;
        miscompares = miscompares + 1;
        report_and_stop;
    end
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
        aresetn = 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 8; i = i + 1) rdchk(8'(i * 4), (i == 7) ? 32'hc8fa : 0, -1);
        wr(8'h04, 32'ha4);
        rdchk(8'h04, 0, -1);
        rdchk(8'h20, 0, -1);
        $display("test reset and enable done");
        wr(8'h18, 32'h10);
        wr(8'h04, 32'ha4);
        rdchk(8'h04, 32'ha4, -1);
        wr(8'h1c, 32'h0404);
        wr(8'h0c, 32'h02);
        wr(8'h08, 32'h88);
        rdchk(8'h0c, 32'h02, 32'hc3);
        peer_u.frame(8'ha4, ack);
        @(posedge aclk);
        chk("ack", 1, ack);
        rdchk(8'h10, 32'h12, 32'hba);
        rdchk(8'h00, 32'ha4, -1);
        wr(8'h00, 32'hff);
        peer_u.stop;
        @(posedge aclk);
        rdchk(8'h10, 32'h01, 32'h03);
        chk("irqs", 1, irqs);
        $display("test slave match done");
        peer_u.frame(8'h20, ack);
        peer_u.stop;
        @(posedge aclk);
        chk("ack", 0, ack);
        wr(8'h14, 32'h1);
        peer_u.frame(8'ha4, ack);
        @(posedge aclk);
        chk("irqs", 2, irqs);
        wr(8'h08, 32'hc8);
        rdchk(8'h08, 32'h88, -1);
        rdchk(8'h10, 32'h00, 32'hba);
        wr(8'h0c, 32'h03);
        wr(8'h08, 32'h8a);
        rdchk(8'h0c, 32'hc1, 32'hc1);
        wr(8'h14, 32'h0);
        wr(8'h0c, 32'h00);
        wr(8'h08, 32'h9a);
        rdchk(8'h08, 32'h9a, -1);
        peer_u.stop;
        repeat (40) @(posedge aclk);
        chk("irqs", 3, irqs);
        rdchk(8'h10, 32'h82, 32'h82);
        wr(8'h00, 32'h00);
        $display("test wakeup, exit and start done");
        report_and_stop;
    end
endmodule // testbench
